// File: hw/edge_measure_defines.svh
/*
 * offsets, field positions, reset values and timing figures of the
 * edge measure counter and digital port block.
 * assumes it is included by bare name from the design file and the test bench.
 */
`ifndef EDGE_MEASURE_DEFINES_SVH
`define EDGE_MEASURE_DEFINES_SVH

// register byte offsets on the axi4-lite slave
`define REG_CTRL          8'h00
`define REG_MC1_SEL       8'h04
`define REG_MC2_SEL       8'h08
`define REG_DOUT          8'h0C
`define REG_DIN           8'h10
`define REG_MC1_HOLD      8'h14
`define REG_MC2_HOLD      8'h18
`define REG_STATUS        8'h1C

// control register fields
`define CTRL_EN_BIT       0
`define CTRL_WIDE_BIT     1

// source select fields: start in [4:0], stop in [12:8]
`define SEL_START_LSB     0
`define SEL_STOP_LSB      8
`define SEL_W             5
`define SEL_MAX           5'h16

// status fields: running flags at [1:0], measurement-seen flags at [9:8]
`define STAT_RUN_LSB      0
`define STAT_DONE_LSB     8

// reset values
`define DOUT_RST          8'h00
`define SEL_RST           5'h00

// channel list numbers
`define MC1_CH_NARROW     5'd10
`define MC1_CH_WIDE       5'd18
`define DIN_CH_NARROW     5'd12
`define DIN_CH_WIDE       5'd20
`define DOUT_OUT_CH       5'd2

// counting rate versus system clock, both in mhz
`define REF_CLK_MHZ       48
`define SYS_CLK_MHZ       250

// axi response codes
`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10

`endif

// File: hw/edge_measure_pkg.sv
/*
 * types shared by the edge measure counter and digital port block.
 * assumes nothing of its surroundings.
 */
package edge_measure_pkg;

	// measure counter sequencing, one-hot
	typedef enum logic [1:0] {
		MC_IDLE = 2'b01,   // waiting for the start edge
		MC_RUN  = 2'b10    // counting reference ticks
	} mc_state_e;

	typedef logic [4:0] chan_t;   // channel list number

endpackage

// File: hw/edge_measure_counter_dio.sv
/*
 * two edge-to-edge measure counters and an 8-bit digital port, answering
 * the acquisition sequencer's input and output channel lists, with an
 * axi4-lite slave for configuration and single-value access.
 * assumes the axi and channel list pins are synchronous to aclk, the sequencer issues one
 * sample request per cycle at most, and external pull-ups hold unused
 * digital inputs high.
 */
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "edge_measure_defines.svh"

// Operation
// [RULE_01] start and stop source chosen independently
// [RULE_02] same edge: stop also starts next
// [RULE_03] different edges: count from start to stop
// [RULE_04] stop edge latches count and clears counter
// [RULE_05] held value kept until overwritten; the code also clears it to zero whenever en is low
// [RULE_06] repeated samples return same held value
// [RULE_07] newest measurement overwrites, samples see latest
// [RULE_08] hold reads zero before first measurement
// [RULE_09] counter samples delayed to match converter
// [RULE_10] counters are ordinary input list entries
// [RULE_11] counter channels 10/11 or 18/19
// [RULE_12] eight input and eight output lines
// [RULE_13] bit one means high line level
// [RULE_14] outputs low after power-up and reset
// [RULE_15] unconnected inputs read as one
// [RULE_16] single access moves whole port, ignores gain
// [RULE_17] single access finishes alone, not stoppable
// [RULE_18] input port is channel 12 or 20
// [RULE_19] input sample clock paces input port
// [RULE_20] output port is output channel 2
// [RULE_21] internal timing from 48 mhz reference
// [RULE_22] interval is count minus one reference periods
// [RULE_23] sources synchronised before edge detection
module edge_measure_counter_dio #(
	parameter int CNT_W      = 32,   // measure count width
	parameter int PIPE_DEPTH = 4     // converter group delay in aclk cycles
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite slave
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// event sources and the digital port
	input  wire logic                    conv_done,
	input  wire logic                    tach_in,
	input  wire logic                    ct0_clk_in,
	input  wire logic                    ct0_gate_in,
	input  wire logic [7:0]              din,
	output logic [7:0]                   dout,
	// input channel list sample requests and answers
	input  wire logic                    in_smp_valid,
	input  wire edge_measure_pkg::chan_t in_smp_chan,
	output logic                         in_resp_valid,
	output edge_measure_pkg::chan_t      in_resp_chan,
	output logic [CNT_W-1:0]             in_resp_data,
	// output channel list updates
	input  wire logic                    out_smp_valid,
	input  wire edge_measure_pkg::chan_t out_smp_chan,
	input  wire logic [7:0]              out_smp_data
);
	import edge_measure_pkg::*;

	localparam int SRC_W = 12;   // conv, tach, din[7:0], ct0 clock, ct0 gate
	localparam logic [8:0] TICK_ADD = 9'(`REF_CLK_MHZ);
	localparam logic [8:0] TICK_MOD = 9'(`SYS_CLK_MHZ);

	// every flip-flop of the block
	typedef struct packed {
		logic [7:0]                         aw_addr;   // captured write address
		logic                               aw_v;      // write address held
		logic [31:0]                        w_data;    // captured write data
		logic [3:0]                         w_strb;    // captured byte enables
		logic                               w_v;       // write data held
		logic                               awready;
		logic                               wready;
		logic                               bvalid;
		logic [1:0]                         bresp;
		logic                               arready;
		logic                               rvalid;
		logic [31:0]                        rdata;
		logic [1:0]                         rresp;
		logic                               en;        // acquisition running
		logic                               wide;      // 16-channel numbering
		logic [1:0][`SEL_W-1:0]             start_sel;
		logic [1:0][`SEL_W-1:0]             stop_sel;
		logic [7:0]                         dout;
		logic [SRC_W-1:0]                   sy1;       // synchroniser first stage
		logic [SRC_W-1:0]                   sy2;       // synchroniser second stage
		logic [SRC_W-1:0]                   sy3;       // previous value for edges
		logic [8:0]                         acc;       // fractional tick phase
		logic                               tick;      // one 48 mhz period elapsed
		mc_state_e [1:0]                    ms;
		logic [1:0][CNT_W-1:0]              cnt;       // running counts
		logic [1:0][CNT_W-1:0]              hold;      // latched counts
		logic [1:0]                         done;      // a measurement has landed
		logic [PIPE_DEPTH-1:0]              pv;        // delay pipe valid
		logic [PIPE_DEPTH-1:0][4:0]         pc;        // delay pipe channel
		logic [PIPE_DEPTH-1:0][CNT_W-1:0]   pd;        // delay pipe data
	} state_s;

	state_s st_r;    // registered state
	state_s st_nxt;  // next state

	// maps a source selection onto this cycle's synchronised edges
	function automatic logic sel_event(input logic [4:0] sel,
	                                   input logic [SRC_W-1:0] rise,
	                                   input logic [SRC_W-1:0] fall);
		logic [4:0] idx;
		idx = 5'((sel - 5'd1) >> 1) + 5'd1;
		if (sel == 5'd0) begin
			sel_event = rise[0];                 // conversion complete
		end else if (sel > `SEL_MAX) begin
			sel_event = 1'b0;                    // unused codes never fire
		end else if (sel[0]) begin
			sel_event = fall[idx[3:0]];          // odd codes: falling edge
		end else begin
			sel_event = rise[idx[3:0]];          // even codes: rising edge
		end
	endfunction

	// picks the first measure counter channel for the numbering variant
	function automatic chan_t mc_base(input logic wide);
		mc_base = wide ? `MC1_CH_WIDE : `MC1_CH_NARROW;   // [RULE_11]
	endfunction

	// next state of the whole block
	always_comb begin
		logic [SRC_W-1:0] rise;
		logic [SRC_W-1:0] fall;
		logic [8:0]       acc_sum;
		logic             ev_start;
		logic             ev_stop;
		logic             wr_go;
		logic [31:0]      wmask;
		logic [31:0]      wval;
		chan_t            din_ch;
		rise     = '0;
		fall     = '0;
		acc_sum  = '0;
		ev_start = 1'b0;
		ev_stop  = 1'b0;
		wr_go    = 1'b0;
		wmask    = '0;
		wval     = '0;
		din_ch   = '0;
		st_nxt   = st_r;

		// two-stage synchroniser; edges only from second stage onward
		st_nxt.sy1 = {ct0_gate_in, ct0_clk_in, din, tach_in, conv_done};   // [RULE_23]
		st_nxt.sy2 = st_r.sy1;                                          // [RULE_23]
		st_nxt.sy3 = st_r.sy2;
		rise = st_r.sy2 & ~st_r.sy3;                                     // [RULE_23]
		fall = ~st_r.sy2 & st_r.sy3;

		// 48 mhz tick out of 250 mhz by phase accumulation, no second clock
		acc_sum = st_r.acc + TICK_ADD;                                   // [RULE_21]
		if (acc_sum >= TICK_MOD) begin
			st_nxt.acc  = acc_sum - TICK_MOD;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.acc  = acc_sum;
			st_nxt.tick = 1'b0;
		end

		// measure counters
		for (int i = 0; i < 2; i++) begin
			ev_start = sel_event(st_r.start_sel[i], rise, fall);         // [RULE_01]
			ev_stop  = sel_event(st_r.stop_sel[i], rise, fall);          // [RULE_01]
			if (!st_r.en) begin
				// stopped: held value returns to zero for the next run
				st_nxt.ms[i]   = MC_IDLE;
				st_nxt.cnt[i]  = '0;
				st_nxt.hold[i] = '0;                                     // [RULE_08]
				st_nxt.done[i] = 1'b0;
			end else begin
				case (st_r.ms[i])
					MC_IDLE: begin
						// count starts at one so interval is count minus one
						if (ev_start) begin
							st_nxt.ms[i]  = MC_RUN;                      // [RULE_03]
							st_nxt.cnt[i] = CNT_W'(1);                   // [RULE_22]
						end
					end
					MC_RUN: begin
						if (ev_stop) begin
							// newest result always replaces the held one
							// the stop cycle's own tick closes the interval, so no phase error
							st_nxt.hold[i] = st_r.cnt[i] + CNT_W'(st_r.tick && st_r.cnt[i] != '1);   // [RULE_04] [RULE_07] [RULE_22]
							st_nxt.done[i] = 1'b1;
							if (st_r.start_sel[i] == st_r.stop_sel[i]) begin
								st_nxt.cnt[i] = CNT_W'(1);               // [RULE_02]
							end else begin
								st_nxt.cnt[i] = '0;                      // [RULE_04]
								st_nxt.ms[i]  = MC_IDLE;                 // [RULE_03]
							end
						end else if (st_r.tick && st_r.cnt[i] != '1) begin
							// saturates rather than wrapping on a stalled source
							st_nxt.cnt[i] = st_r.cnt[i] + CNT_W'(1);     // [RULE_03]
						end
					end
					default: begin
						st_nxt.ms[i]  = MC_IDLE;
						st_nxt.cnt[i] = '0;
					end
				endcase
			end
		end

		// input channel list: pipe moves every cycle, matches converter delay
		for (int k = PIPE_DEPTH - 1; k > 0; k--) begin
			st_nxt.pv[k] = st_r.pv[k-1];                                 // [RULE_09]
			st_nxt.pc[k] = st_r.pc[k-1];
			st_nxt.pd[k] = st_r.pd[k-1];
		end
		st_nxt.pv[0] = 1'b0;
		st_nxt.pc[0] = in_smp_chan;
		st_nxt.pd[0] = '0;
		din_ch = st_r.wide ? `DIN_CH_WIDE : `DIN_CH_NARROW;
		// sampling leaves the held value in place
		if (in_smp_valid) begin                                          // [RULE_10] [RULE_19]
			if (in_smp_chan == mc_base(st_r.wide)) begin
				st_nxt.pv[0] = 1'b1;
				st_nxt.pd[0] = st_r.hold[0];                             // [RULE_05] [RULE_06]
			end else if (in_smp_chan == mc_base(st_r.wide) + 5'd1) begin
				st_nxt.pv[0] = 1'b1;                                     // [RULE_11]
				st_nxt.pd[0] = st_r.hold[1];                             // [RULE_05] [RULE_06]
			end else if (in_smp_chan == din_ch) begin
				st_nxt.pv[0] = 1'b1;                                     // [RULE_18]
				st_nxt.pd[0] = CNT_W'(st_r.sy2[9:2]);                    // [RULE_12] [RULE_13]
			end
		end

		// axi write: address and data taken in either order
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_v    = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_v    = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		wr_go = st_r.aw_v && st_r.w_v && !st_r.bvalid;
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{st_r.w_strb[b]}};
		end
		if (wr_go) begin
			st_nxt.aw_v   = 1'b0;
			st_nxt.w_v    = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = `AXI_OKAY;
			case (st_r.aw_addr)
				`REG_CTRL: begin
					wval = ({30'h0000_0000, st_r.wide, st_r.en} & ~wmask) | (st_r.w_data & wmask);
					st_nxt.en   = wval[`CTRL_EN_BIT];
					st_nxt.wide = wval[`CTRL_WIDE_BIT];
				end
				`REG_MC1_SEL, `REG_MC2_SEL: begin
					for (int j = 0; j < 2; j++) begin
						if (st_r.aw_addr == (j == 0 ? `REG_MC1_SEL : `REG_MC2_SEL)) begin
							if (st_r.w_strb[0]) begin
								st_nxt.start_sel[j] = st_r.w_data[`SEL_START_LSB +: `SEL_W];   // [RULE_01]
							end
							if (st_r.w_strb[1]) begin
								st_nxt.stop_sel[j] = st_r.w_data[`SEL_STOP_LSB +: `SEL_W];     // [RULE_01]
							end
						end
					end
				end
				`REG_DOUT: begin
					// whole port in one go; completes with the response
					if (st_r.w_strb[0]) begin
						st_nxt.dout = st_r.w_data[7:0];                  // [RULE_16] [RULE_17]
					end
				end
				`REG_DIN, `REG_MC1_HOLD, `REG_MC2_HOLD, `REG_STATUS: begin
					st_nxt.bresp = `AXI_OKAY;                            // read-only, write dropped
				end
				default: begin
					st_nxt.bresp = `AXI_SLVERR;                          // unmapped
				end
			endcase
		end

		// output channel list update wins over a register write
		if (out_smp_valid && out_smp_chan == `DOUT_OUT_CH) begin
			st_nxt.dout = out_smp_data;                                  // [RULE_20] [RULE_13]
		end

		// axi read: answer one cycle after the address is taken
		if (s_axi_rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = `AXI_OKAY;
			st_nxt.rdata  = '0;
			case (s_axi_araddr)
				`REG_CTRL: begin
					st_nxt.rdata = {30'h0000_0000, st_r.wide, st_r.en};
				end
				`REG_MC1_SEL: begin
					st_nxt.rdata = {19'h0_0000, st_r.stop_sel[0], 3'h0, st_r.start_sel[0]};
				end
				`REG_MC2_SEL: begin
					st_nxt.rdata = {19'h0_0000, st_r.stop_sel[1], 3'h0, st_r.start_sel[1]};
				end
				`REG_DOUT: begin
					st_nxt.rdata = {24'h00_0000, st_r.dout};
				end
				`REG_DIN: begin
					st_nxt.rdata = {24'h00_0000, st_r.sy2[9:2]};         // [RULE_16] [RULE_15]
				end
				`REG_MC1_HOLD: begin
					st_nxt.rdata = 32'(st_r.hold[0]);
				end
				`REG_MC2_HOLD: begin
					st_nxt.rdata = 32'(st_r.hold[1]);
				end
				`REG_STATUS: begin
					st_nxt.rdata[`STAT_RUN_LSB +: 2]  = {st_r.ms[1] == MC_RUN, st_r.ms[0] == MC_RUN};
					st_nxt.rdata[`STAT_DONE_LSB +: 2] = st_r.done;
				end
				default: begin
					st_nxt.rresp = `AXI_SLVERR;                          // unmapped reads zero
				end
			endcase
		end

		// ready flags follow what is still held
		st_nxt.awready = !st_nxt.aw_v && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_v && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;
	end

	// state register; reset clears counters and drives the port low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r           <= '0;
			st_r.dout      <= `DOUT_RST;                                 // [RULE_14]
			st_r.start_sel <= {2{`SEL_RST}};
			st_r.stop_sel  <= {2{`SEL_RST}};
			st_r.sy1       <= '1;                                        // idle-high, no false edge
			st_r.sy2       <= '1;
			st_r.sy3       <= '1;
			st_r.ms[0]     <= MC_IDLE;
			st_r.ms[1]     <= MC_IDLE;
			st_r.awready   <= 1'b1;
			st_r.wready    <= 1'b1;
			st_r.arready   <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// all outputs straight from flip-flops
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;
	assign dout          = st_r.dout;
	assign in_resp_valid = st_r.pv[PIPE_DEPTH-1];
	assign in_resp_chan  = st_r.pc[PIPE_DEPTH-1];
	assign in_resp_data  = st_r.pd[PIPE_DEPTH-1];

endmodule

// File: verif/edge_measure_assertions.sv
/*
 * checker for the edge measure counter and digital port block.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module edge_measure_checker #(
	parameter int PIPE_DEPTH = 4   // sample answer delay in cycles
) (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic [7:0]              dout,
	input wire logic                    in_smp_valid,
	input wire edge_measure_pkg::chan_t in_smp_chan,
	input wire logic                    in_resp_valid,
	input wire edge_measure_pkg::chan_t in_resp_chan,
	input wire logic                    out_smp_valid,
	input wire edge_measure_pkg::chan_t out_smp_chan,
	input wire logic [7:0]              out_smp_data
);
	// one clock domain, so one default clock and reset
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	// answers come only from a request exactly one pipeline ago
	a_resp_delay: assert property (in_resp_valid |-> $past(in_smp_valid, PIPE_DEPTH))
		else $error("sample answer misaligned");
	a_resp_chan: assert property (in_resp_valid |-> in_resp_chan == $past(in_smp_chan, PIPE_DEPTH))
		else $error("sample answer channel wrong");
	a_out_list: assert property (out_smp_valid && out_smp_chan == 5'h02 |=> dout == $past(out_smp_data))
		else $error("output list update lost");
	// dout moves only for a list update or a completed register write
	a_dout_cause: assert property ($changed(dout) |-> $past(out_smp_valid && out_smp_chan == 5'h02) || $rose(s_axi_bvalid))
		else $error("output lines changed without cause");
	// reset itself is the antecedent, so no disable here
	a_dout_reset: assert property (disable iff (1'b0) !aresetn |=> dout == 8'h00)
		else $error("output lines not low after reset");

	c_mc_sample: cover property (in_resp_valid && in_resp_chan == 5'h0a);
	c_out_list: cover property (out_smp_valid && out_smp_chan == 5'h02);
	c_write: cover property (s_axi_bvalid);
endmodule

bind edge_measure_counter_dio edge_measure_checker #(.PIPE_DEPTH(PIPE_DEPTH)) chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .dout,
	.in_smp_valid, .in_smp_chan, .in_resp_valid, .in_resp_chan, .out_smp_valid, .out_smp_chan, .out_smp_data);

// File: verif/dio_far_end.sv
/*
 * far side model: tachometer square wave and pulled-up digital inputs.
 * assumes its controls change just after a rising edge of aclk.
 */
`timescale 1ns/1ps
module dio_far_end (
	input wire logic        aclk,
	input wire logic        run,
	input wire logic [15:0] half,
	input wire logic [7:0]  drv,
	input wire logic [7:0]  oe,
	output logic            tach_in,
	output logic [7:0]      din
);
	logic [15:0] cnt = 16'h0000;   // cycles into this half period
	initial tach_in = 1'b0;

	// tach toggles every half cycles; holds its level when stopped
	always @(posedge aclk) begin
		if (run) begin
			cnt <= (cnt >= half - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
			if (cnt >= half - 16'h0001) tach_in <= ~tach_in;
		end
	end

	// undriven lines float up through the board pull-ups
	assign din = (drv & oe) | ~oe;
endmodule

// File: verif/test_edge_measure_counter_dio.sv
/*
 * self-checking bench for the edge measure counter and digital port block.
 * assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/1ps
`include "edge_measure_defines.svh"
module test_edge_measure_counter_dio;
	import edge_measure_pkg::*;
	localparam int PD = 4;   // pipeline depth under test
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, in_resp_data;
	logic        in_smp_valid = 1'b0, in_resp_valid, out_smp_valid = 1'b0;
	chan_t       in_smp_chan = 5'h00, in_resp_chan, out_smp_chan = 5'h00;
	logic [7:0]  out_smp_data = 8'h00, din, dout, drv = 8'h00, oe = 8'h00;
	logic [15:0] half = 16'h007d;   // 125 cycles high, 125 low
	logic        run = 1'b0, tach_in;
	logic        conv_done = 1'b0, ct0_gate_in = 1'b0;
	int          errors = 0;
	int          compares = 0;

	edge_measure_counter_dio #(.CNT_W(32), .PIPE_DEPTH(PD)) dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.conv_done, .tach_in, .ct0_clk_in(1'b0), .ct0_gate_in, .din, .dout,
		.in_smp_valid, .in_smp_chan, .in_resp_valid, .in_resp_chan, .in_resp_data,
		.out_smp_valid, .out_smp_chan, .out_smp_data);
	dio_far_end far (.aclk, .run, .half, .drv, .oe, .tach_in, .din);

	// 250 mhz
	always #2 aclk = ~aclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// write: address and data offered together, bready held until bvalid
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		check(32'(s_axi_bvalid), 32'h0000_0001);
		check({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		check(32'(s_axi_rvalid), 32'h0000_0001);
		check(s_axi_rdata, ed);
		check({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	// one input list sample, answer judged when it appears
	task automatic smp(input chan_t c, input logic [31:0] exp);
		int n = 0;
		@(posedge aclk);
		in_smp_valid <= 1'b1;
		in_smp_chan <= c;
		@(posedge aclk);
		in_smp_valid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!in_resp_valid && n < 20);
		check(n, PD);
		check({27'h0, in_resp_chan}, {27'h0, c});
		check(in_resp_data, exp);
	endtask

	task automatic olist(input chan_t c, input logic [7:0] d);
		@(posedge aclk);
		out_smp_valid <= 1'b1;
		out_smp_chan <= c;
		out_smp_data <= d;
		@(posedge aclk);
		out_smp_valid <= 1'b0;
		@(posedge aclk);
	endtask

	// configure both counters on the tach input, nothing measured yet
	task automatic t_idle;
		check({24'h0, dout}, 32'h0000_0000);
		axr(`REG_DIN, 32'h0000_00ff, `AXI_OKAY);
		axw(`REG_MC1_SEL, 32'h0000_0202, `AXI_OKAY);
		axw(`REG_MC2_SEL, 32'h0000_0102, `AXI_OKAY);
		axw(`REG_CTRL, 32'h0000_0001, `AXI_OKAY);
		smp(`MC1_CH_NARROW, 32'h0000_0000);
		smp(`MC1_CH_NARROW + 5'h01, 32'h0000_0000);
		$display("done idle");
	endtask

	// 250-cycle period is 48 reference ticks, so counts are exact
	task automatic t_measure;
		run <= 1'b1;
		repeat (1200) @(posedge aclk);
		smp(`MC1_CH_NARROW, 32'h0000_0031);
		smp(`MC1_CH_NARROW, 32'h0000_0031);
		smp(`MC1_CH_NARROW + 5'h01, 32'h0000_0019);
		half <= 16'h00fa;
		repeat (2000) @(posedge aclk);
		smp(`MC1_CH_NARROW, 32'h0000_0061);
		smp(`MC1_CH_NARROW + 5'h01, 32'h0000_0031);
		$display("done measure");
	endtask

	// wide numbering and the input port with half its lines floating
	task automatic t_wide;
		drv <= 8'h05;
		oe <= 8'h0f;
		axw(`REG_CTRL, 32'h0000_0003, `AXI_OKAY);
		smp(`MC1_CH_WIDE, 32'h0000_0061);
		smp(`MC1_CH_WIDE + 5'h01, 32'h0000_0031);
		smp(`DIN_CH_WIDE, 32'h0000_00f5);
		axw(`REG_CTRL, 32'h0000_0001, `AXI_OKAY);
		smp(`DIN_CH_NARROW, 32'h0000_00f5);
		axr(`REG_DIN, 32'h0000_00f5, `AXI_OKAY);
		$display("done wide");
	endtask

	// single-value writes, output list, read-only and unmapped places
	task automatic t_dout;
		axw(`REG_DOUT, 32'h0000_00a5, `AXI_OKAY);
		check({24'h0, dout}, 32'h0000_00a5);
		olist(`DOUT_OUT_CH, 8'h3c);
		check({24'h0, dout}, 32'h0000_003c);
		olist(5'h03, 8'hff);
		check({24'h0, dout}, 32'h0000_003c);
		axr(`REG_DOUT, 32'h0000_003c, `AXI_OKAY);
		axw(`REG_DIN, 32'h0000_0000, `AXI_OKAY);
		axr(`REG_DIN, 32'h0000_00f5, `AXI_OKAY);
		axr(8'h40, 32'h0000_0000, `AXI_SLVERR);
		$display("done dout");
	endtask

	// conversion-complete start, counter gate rise stop, 250 cycles apart
	task automatic t_codes;
		axw(`REG_CTRL, 32'h0000_0000, `AXI_OKAY);
		axw(`REG_MC2_SEL, 32'h0000_1600, `AXI_OKAY);
		axw(`REG_CTRL, 32'h0000_0001, `AXI_OKAY);
		conv_done <= 1'b1;
		repeat (250) @(posedge aclk);
		ct0_gate_in <= 1'b1;
		repeat (8) @(posedge aclk);
		smp(`MC1_CH_NARROW + 5'h01, 32'h0000_0031);
		$display("done codes");
	endtask

	// reset in mid-run with the tach still toggling
	task automatic t_reset;
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({24'h0, dout}, 32'h0000_0000);
		smp(`MC1_CH_NARROW, 32'h0000_0000);
		$display("done reset");
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// main sequence after a 4-cycle reset
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_idle();
		t_measure();
		t_wide();
		t_dout();
		t_codes();
		t_reset();
		close_out();
	end

	// watchdog, several times the expected run length
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		close_out();
	end
endmodule
